/* File: rtl/aps_pkg.sv */
// aps_pkg: constants for the supply-side auxiliary cable sideband logic
// assumes a 200 MHz clock and AXI4-Lite register access
package aps_pkg;
    localparam int unsigned CLK_HZ = 200_000_000;
    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT = 8'h08;
    localparam logic [7:0] REG_IRQ_EN = 8'h0C;
    localparam logic [7:0] REG_IRQ_CLR = 8'h10;
    // control fields
    localparam int unsigned CTRL_LEVEL_LSB = 0;
    localparam int unsigned CTRL_FAULT_CLR_BIT = 4;
    // status fields
    localparam int unsigned ST_LEVEL_LSB = 0;
    localparam int unsigned ST_FAULT_BIT = 4;
    localparam int unsigned ST_PGOOD_BIT = 5;
    localparam int unsigned ST_PRESENT_BIT = 6;
    localparam int unsigned ST_LOCKED_BIT = 7;
    // interrupt bits
    localparam int unsigned IRQ_FAULT_BIT = 0;
    localparam int unsigned IRQ_CABLE_BIT = 1;
    localparam int unsigned IRQ_W = 2;
    // power level selections
    typedef enum logic [2:0] {
        APS_LVL_0W = 3'h0,
        APS_LVL_150W = 3'h1,
        APS_LVL_300W = 3'h2,
        APS_LVL_450W = 3'h3,
        APS_LVL_600W = 3'h4
    } aps_level_t;
    localparam logic [2:0] CTRL_RESET_LEVEL = 3'h0;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

/* File: rtl/aps_sideband.sv */
// aps_sideband: supply-side sideband logic for a 12 V auxiliary card cable
// assumes open-drain code lines with external pull-ups; AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none
module aps_sideband (
    input wire logic clock_i,
    input wire logic rst_n_i,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // supply state
    input wire logic supply_power_on_n_i,
    input wire logic main_rails_good_i,
    // code lines: ground drive enables and line-to-line join switch
    output logic power_code_line_a_gnd_o,
    output logic power_code_line_b_gnd_o,
    output logic power_code_join_o,
    // card sideband inputs and status outputs
    input wire logic card_power_good_i,
    input wire logic cable_present_n_i,
    output logic card_fault_o,
    output logic cable_absent_o,
    output logic irq_o
);
    import aps_pkg::*;

    typedef struct packed {
        logic aw_full;
        logic [7:0] aw_addr;
        logic w_full;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [2:0] level_req;
        logic [2:0] level;
        logic a_gnd;
        logic b_gnd;
        logic join_l;
        logic fault;
        logic absent_prev;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_en;
    } aps_state_t;

    aps_state_t q, d;
    logic pgood_s, present_n_s, locked;

    aps_sync #(.RESET_VAL(1'b1)) u_sync_pg (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .async_i(card_power_good_i),
        .sync_o(pgood_s)
    );
    aps_sync #(.RESET_VAL(1'b1)) u_sync_cp (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .async_i(cable_present_n_i),
        .sync_o(present_n_s)
    );

    // code is frozen unless in standby with main rails off
    assign locked = !supply_power_on_n_i || main_rails_good_i;

    function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction

    logic do_write, do_read;
    logic [31:0] wval, status_v;
    logic fault_clr;
    logic [IRQ_W-1:0] irq_clr, irq_set;

    always_comb begin
        d = q;
        wval = '0;
        fault_clr = 1'b0;
        irq_clr = '0;
        status_v = '0;
        // write channel: address and data in either order
        if (s_axi_awvalid_i && s_axi_awready_o) begin
            d.aw_full = 1'b1;
            d.aw_addr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s_axi_wready_o) begin
            d.w_full = 1'b1;
            d.w_data = s_axi_wdata_i;
            d.w_strb = s_axi_wstrb_i;
        end
        do_write = q.aw_full && q.w_full && !q.bvalid;
        if (do_write) begin
            d.aw_full = 1'b0;
            d.w_full = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = AXI_OKAY;
            unique case (q.aw_addr)
                REG_CTRL: begin
                    wval = apply_strb({29'h0, q.level_req}, q.w_data, q.w_strb);
                    d.level_req = wval[CTRL_LEVEL_LSB +: 3];
                    fault_clr = wval[CTRL_FAULT_CLR_BIT];
                end
                REG_IRQ_EN: begin
                    wval = apply_strb({30'h0, q.irq_en}, q.w_data, q.w_strb);
                    d.irq_en = wval[IRQ_W-1:0];
                end
                REG_IRQ_CLR: begin
                    wval = apply_strb('0, q.w_data, q.w_strb);
                    irq_clr = wval[IRQ_W-1:0];
                end
                REG_STATUS, REG_IRQ_STAT: ;
                default: d.bresp = AXI_SLVERR;
            endcase
        end
        if (q.bvalid && s_axi_bready_i) begin
            d.bvalid = 1'b0;
        end
        // read channel
        status_v[ST_LEVEL_LSB +: 3] = q.level;
        status_v[ST_FAULT_BIT] = q.fault;
        status_v[ST_PGOOD_BIT] = pgood_s;
        status_v[ST_PRESENT_BIT] = !present_n_s;
        status_v[ST_LOCKED_BIT] = locked;
        do_read = s_axi_arvalid_i && s_axi_arready_o;
        if (do_read) begin
            d.rvalid = 1'b1;
            d.rresp = AXI_OKAY;
            unique case (s_axi_araddr_i)
                REG_CTRL: d.rdata = {29'h0, q.level_req};
                REG_STATUS: d.rdata = status_v;
                REG_IRQ_STAT: d.rdata = {30'h0, q.irq_stat};
                REG_IRQ_EN: d.rdata = {30'h0, q.irq_en};
                REG_IRQ_CLR: d.rdata = '0;
                default: begin
                    d.rdata = '0;
                    d.rresp = AXI_SLVERR;
                end
            endcase
        end else if (q.rvalid && s_axi_rready_i) begin
            d.rvalid = 1'b0;
        end
        // apply a new code only while unlocked
        if (!locked) begin
            d.level = q.level_req;
        end
        // code drive formed entirely inside the supply
        unique case (aps_level_t'(q.level))
            APS_LVL_600W: {d.a_gnd, d.b_gnd, d.join_l} = 3'b110;
            APS_LVL_450W: {d.a_gnd, d.b_gnd, d.join_l} = 3'b010;
            APS_LVL_300W: {d.a_gnd, d.b_gnd, d.join_l} = 3'b100;
            APS_LVL_150W: {d.a_gnd, d.b_gnd, d.join_l} = 3'b001;
            default: {d.a_gnd, d.b_gnd, d.join_l} = 3'b000;
        endcase
        // sticky fault, set wins over clear
        if (fault_clr) begin
            d.fault = 1'b0;
        end
        if (!pgood_s) begin
            d.fault = 1'b1;
        end
        // interrupts: fault and cable removal
        d.absent_prev = present_n_s;
        irq_set = '0;
        irq_set[IRQ_FAULT_BIT] = !pgood_s;
        irq_set[IRQ_CABLE_BIT] = present_n_s && !q.absent_prev;
        d.irq_stat = (q.irq_stat & ~irq_clr) | irq_set;
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            q <= '0;
            q.level_req <= CTRL_RESET_LEVEL;
            q.level <= CTRL_RESET_LEVEL;
            q.absent_prev <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign s_axi_awready_o = !q.aw_full;
    assign s_axi_wready_o = !q.w_full;
    assign s_axi_bvalid_o = q.bvalid;
    assign s_axi_bresp_o = q.bresp;
    assign s_axi_arready_o = !q.rvalid;
    assign s_axi_rvalid_o = q.rvalid;
    assign s_axi_rdata_o = q.rdata;
    assign s_axi_rresp_o = q.rresp;
    assign power_code_line_a_gnd_o = q.a_gnd;
    assign power_code_line_b_gnd_o = q.b_gnd;
    assign power_code_join_o = q.join_l;
    assign card_fault_o = q.fault;
    assign cable_absent_o = present_n_s;
    assign irq_o = |(q.irq_stat & q.irq_en);

    join_floats_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        q.join_l |-> !q.a_gnd && !q.b_gnd) else $error("joined lines grounded");
    level_150_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        q.level == APS_LVL_150W |=> power_code_join_o && !power_code_line_a_gnd_o
        && !power_code_line_b_gnd_o)
        else $error("150 W code wrong");
    code_frozen_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        locked && $past(locked) |-> $stable(q.level)) else $error("code changed while locked");
    code_standby_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !locked |=> q.level == $past(q.level_req)) else $error("standby code not applied");
    drive_600_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        q.level == APS_LVL_600W |=> q.a_gnd && q.b_gnd && !q.join_l)
        else $error("600 W code wrong");
    fault_latch_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !pgood_s || (card_fault_o && !fault_clr) |=> card_fault_o)
        else $error("fault not latched");
    fault_irq_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !pgood_s |=> q.irq_stat[IRQ_FAULT_BIT]) else $error("fault alert missing");
    absent_flag_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $rose(present_n_s) |=> q.irq_stat[IRQ_CABLE_BIT]) else $error("removal not flagged");
endmodule // aps_sideband
`default_nettype wire

/* File: rtl/aps_sync.sv */
// aps_sync: two-stage synchroniser for one sideband level
// assumes the input may change at any time relative to clock_i
`timescale 1ns/1ps
`default_nettype none
module aps_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic async_i,
    output logic sync_o
);
    typedef struct packed {
        logic meta;
        logic sync;
    } aps_sync_state_t;
    aps_sync_state_t st_q, st_d;
    always_comb begin
        st_d.meta = async_i;
        st_d.sync = st_q.meta;
    end
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            st_q <= '{meta: RESET_VAL, sync: RESET_VAL};
        end else begin
            st_q <= st_d;
        end
    end
    assign sync_o = st_q.sync;
endmodule // aps_sync
`default_nettype wire

/* File: testbench/aps_card_model.sv */
// aps_card_model: add-in card at the far end of the auxiliary cable
// assumes supply code-line drive outputs; pull-ups sit on sideband lines
`timescale 1ns/1ps
`default_nettype none
module aps_card_model #(
    parameter int HOLD = 20
) (
    input wire logic clock_i,
    input wire logic a_gnd_i,
    input wire logic b_gnd_i,
    input wire logic join_i,
    input wire logic attached_i,
    input wire logic rail_fault_i,
    output logic power_good_o,
    output logic cable_present_n_o,
    output logic [9:0] init_w_o,
    output logic [9:0] max_w_o
);
    logic lo_a;
    logic lo_b;
    int hold_q = 0;
    // decode uses code lines only, never presence; limit is for this cable
    always_comb begin
        lo_a = a_gnd_i | (join_i & b_gnd_i);
        lo_b = b_gnd_i | (join_i & a_gnd_i);
        if (lo_a && lo_b) begin
            {init_w_o, max_w_o} = {10'h177, 10'h258};
        end else if (lo_b) begin
            {init_w_o, max_w_o} = {10'h0E1, 10'h1C2};
        end else if (lo_a) begin
            {init_w_o, max_w_o} = {10'h096, 10'h12C};
        end else if (join_i) begin
            {init_w_o, max_w_o} = {10'h064, 10'h096};
        end else begin
            {init_w_o, max_w_o} = 20'h0;
        end
    end
    // fault pull-down stays for HOLD cycles after the rail recovers
    always @(posedge clock_i) begin
        if (rail_fault_i) begin
            hold_q <= HOLD;
        end else if (hold_q != 0) begin
            hold_q <= hold_q - 1;
        end
    end
    assign power_good_o = (hold_q == 0) && !rail_fault_i;
    assign cable_present_n_o = !attached_i;
endmodule // aps_card_model
`default_nettype wire

/* File: testbench/test_aps_sideband.sv */
// test_aps_sideband: self-checking bench for the sideband block
// assumes aps_card_model as far side and a 200 MHz clock
`timescale 1ns/1ps
`default_nettype none
module test_aps_sideband;
    import aps_pkg::*;
    logic clock_i = 1'h0;
    logic rst_n_i = 1'h0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic pwr_on_n = 1'h1, rails_ok = 1'h0, attached = 1'h1, rail_fault = 1'h0;
    logic a_gnd, b_gnd, joined, pgood, pres_n, fault, absent, irq;
    logic [9:0] w_init, w_max;
    logic [9:0] max_e [8] = '{10'h0, 10'h096, 10'h12C, 10'h1C2, 10'h258, 10'h0, 10'h0, 10'h0};
    logic [9:0] ini_e [8] = '{10'h0, 10'h064, 10'h096, 10'h0E1, 10'h177, 10'h0, 10'h0, 10'h0};
    logic [2:0] code_e [8] = '{3'h0, 3'h1, 3'h4, 3'h2, 3'h6, 3'h0, 3'h0, 3'h0};
    int n_errors = 0;
    int n_compared = 0;
    int cyc = 0;
    aps_sideband dut_u (.clock_i, .rst_n_i, .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
        .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
        .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .supply_power_on_n_i(pwr_on_n), .main_rails_good_i(rails_ok),
        .power_code_line_a_gnd_o(a_gnd), .power_code_line_b_gnd_o(b_gnd),
        .power_code_join_o(joined), .card_power_good_i(pgood), .cable_present_n_i(pres_n),
        .card_fault_o(fault), .cable_absent_o(absent), .irq_o(irq));
    aps_card_model card_u (.clock_i, .a_gnd_i(a_gnd), .b_gnd_i(b_gnd), .join_i(joined),
        .attached_i(attached), .rail_fault_i(rail_fault), .power_good_o(pgood),
        .cable_present_n_o(pres_n), .init_w_o(w_init), .max_w_o(w_max));
    always #2.5 clock_i = ~clock_i;
    task automatic print_verdict;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            print_verdict();
        end
    end
    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    // write: both items offered together, each released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ad, wd, ha, hw;
        logic [1:0] rs;
        ad = 1'h0;
        wd = 1'h0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (!(ad && wd)) begin
            @(negedge clock_i);
            ha = awvalid && awready;
            hw = wvalid && wready;
            @(posedge clock_i);
            if (ha) begin
                ad = 1'h1;
                awvalid <= 1'h0;
            end
            if (hw) begin
                wd = 1'h1;
                wvalid <= 1'h0;
            end
        end
        ha = 1'h0;
        while (!ha) begin
            @(negedge clock_i);
            ha = bvalid;
            rs = bresp;
            @(posedge clock_i);
        end
        bready <= 1'h0;
        tick(1);
        chk(rs, er);
    endtask
    // read and compare masked data and response
    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                        input logic [1:0] er);
        logic hs;
        logic [31:0] d;
        logic [1:0] rs;
        hs = 1'h0;
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        while (!hs) begin
            @(negedge clock_i);
            hs = arvalid && arready;
            @(posedge clock_i);
        end
        arvalid <= 1'h0;
        hs = 1'h0;
        while (!hs) begin
            @(negedge clock_i);
            hs = rvalid;
            d = rdata;
            rs = rresp;
            @(posedge clock_i);
        end
        rready <= 1'h0;
        tick(1);
        chk({rs, d & m}, {er, e});
    endtask
    task automatic t_levels;
        chk({a_gnd, b_gnd, joined, irq, w_max}, 14'h0);
        rchk(REG_CTRL, 32'hFFFFFFFF, 32'h0, AXI_OKAY);
        for (int l = 0; l < 8; l++) begin
            wr(REG_CTRL, 32'(l), AXI_OKAY);
            tick(3);
            chk({a_gnd, b_gnd, joined}, code_e[l]);
            chk({w_init, w_max}, {ini_e[l], max_e[l]});
        end
    endtask
    task automatic t_lock;
        wr(REG_CTRL, 32'h1, AXI_OKAY);
        tick(3);
        pwr_on_n <= 1'h0;
        tick(3);
        wr(REG_CTRL, 32'h2, AXI_OKAY);
        tick(3);
        chk({a_gnd, b_gnd, joined}, 3'h1);
        rails_ok <= 1'h1;
        wr(REG_CTRL, 32'h4, AXI_OKAY);
        tick(4);
        chk({a_gnd, b_gnd, joined, w_max}, {3'h1, 10'h096});
        rchk(REG_STATUS, 32'h80, 32'h80, AXI_OKAY);
        pwr_on_n <= 1'h1;
        rails_ok <= 1'h0;
        tick(4);
        chk({a_gnd, b_gnd, joined}, 3'h6);
    endtask
    task automatic t_fault;
        wr(REG_IRQ_EN, 32'h1, AXI_OKAY);
        for (int p = 0; p < 2; p++) begin
            rail_fault <= 1'h1;
            tick(1);
            rail_fault <= 1'h0;
            tick(6);
            chk({fault, irq}, {1'h1, p == 0});
            wr(REG_IRQ_STAT, 32'h0, AXI_OKAY);
            rchk(REG_IRQ_STAT, 32'h1, 32'h1, AXI_OKAY);
            rchk(REG_STATUS, 32'h30, 32'h10, AXI_OKAY);
            tick(30);
            chk(fault, 1'h1);
            wr(REG_IRQ_CLR, 32'h1, AXI_OKAY);
            wr(REG_CTRL, 32'h14, AXI_OKAY);
            tick(3);
            chk({fault, irq}, 2'h0);
            rchk(REG_STATUS, 32'h37, 32'h24, AXI_OKAY);
            rchk(REG_IRQ_STAT, 32'h1, 32'h0, AXI_OKAY);
            wr(REG_IRQ_EN, 32'h0, AXI_OKAY);
        end
    endtask
    task automatic t_cable;
        wr(REG_IRQ_EN, 32'h2, AXI_OKAY);
        wstrb <= 4'hE;
        wr(REG_IRQ_EN, 32'h0, AXI_OKAY);
        wstrb <= 4'hF;
        rchk(REG_IRQ_EN, 32'hFFFFFFFF, 32'h2, AXI_OKAY);
        attached <= 1'h0;
        tick(6);
        chk({absent, irq}, 2'h3);
        rchk(REG_STATUS, 32'h40, 32'h0, AXI_OKAY);
        attached <= 1'h1;
        tick(6);
        wr(REG_IRQ_CLR, 32'h2, AXI_OKAY);
        tick(2);
        chk({absent, irq}, 2'h0);
        rchk(8'h20, 32'hFFFFFFFF, 32'h0, AXI_SLVERR);
        wr(8'h20, 32'h1, AXI_SLVERR);
    endtask
    initial begin
        tick(10);
        rst_n_i <= 1'h1;
        tick(1);
        t_levels();
        t_lock();
        t_fault();
        t_cable();
        print_verdict();
    end
endmodule // test_aps_sideband
`default_nettype wire
